// >>> logic/etg_ctrl.sv
`timescale 1ns/1ps
module etg_ctrl
    import etg_pkg::*;
#(
    parameter bit ALT_MODEL = 1'b0
) (
    input  wire logic              clk_i,
    input  wire logic              resetn_i,
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [DATA_W-1:0] wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [DATA_W-1:0] rdata_o,
    input  wire logic              trigger_i,
    input  wire logic              master_start_i,
    output logic                   exposure_o,
    output logic                   exp_start_o,
    output logic                   exp_done_o,
    output logic                   tg_tick_o
);

    // ************************************************************
    // Declarations.
    // ************************************************************
    logic [EXP_W-1:0]  exp_period_ff;
    logic [EXP_W-1:0]  nxt_exp_period;
    logic              follower_ff;
    logic              nxt_follower;
    logic              clear_ff;
    logic              nxt_clear;
    logic [DATA_W-1:0] rdata_ff;
    logic [DATA_W-1:0] nxt_rdata;
    logic [ACC_W-1:0]  acc_ff;
    logic [ACC_W-1:0]  nxt_acc;
    logic              tick_ff;
    logic              nxt_tick;
    logic              trig_s1_ff;
    logic              trig_s2_ff;
    logic              trig_s3_ff;
    logic              trig_lvl_ff;
    logic              nxt_trig_lvl;
    logic              trig_rise;
    logic              start_req;
    etg_state_e        state_ff;
    etg_state_e        nxt_state;
    logic [EXP_W-1:0]  count_ff;
    logic [EXP_W-1:0]  nxt_count;
    logic              exposure_ff;
    logic              nxt_exposure;
    logic              start_ff;
    logic              nxt_start;
    logic              done_ff;
    logic              nxt_done;
    logic              wr_ctrl;
    logic [ACC_W:0]    acc_sum;
    logic [ACC_W-1:0]  acc_inc;

    // ************************************************************
    // Register file.
    // ************************************************************

    // Decodes writes and builds the read answer for the next cycle.
    always_comb begin
        wr_ctrl        = wr_i && (addr_i == CTRL_OFS);
        nxt_exp_period = exp_period_ff;
        nxt_follower   = follower_ff;
        nxt_clear      = 1'b0;
        nxt_rdata      = DATA_ZERO;
        if (wr_ctrl) begin
            nxt_exp_period = wdata_i[EXP_MSB:0];
            nxt_follower   = wdata_i[FOL_BIT];
            nxt_clear      = wdata_i[CLR_BIT];
        end
        if (rd_i) begin
            if (addr_i == CTRL_OFS) begin
                nxt_rdata[EXP_MSB:0] = exp_period_ff;
                nxt_rdata[FOL_BIT]   = follower_ff;
            end else if (addr_i == STAT_OFS) begin
                nxt_rdata[EXP_MSB:0]  = count_ff;
                nxt_rdata[BUSY_BIT]   = (state_ff == ETG_EXPOSE);
            end
        end
    end

    // Registers the software visible state and the read data.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            exp_period_ff <= EXP_RST;
            follower_ff   <= FOL_RST;
            clear_ff      <= 1'b0;
            rdata_ff      <= DATA_ZERO;
        end else begin
            exp_period_ff <= nxt_exp_period;
            follower_ff   <= nxt_follower;
            clear_ff      <= nxt_clear;
            rdata_ff      <= nxt_rdata;
        end
    end

    // ************************************************************
    // Generator clock tick.
    // ************************************************************

    // Fractional divider; one carry of the accumulator is one generator clock period.
    always_comb begin
        acc_inc  = ALT_MODEL ? INC_ALT : INC_MAIN;
        acc_sum  = {1'b0, acc_ff} + {1'b0, acc_inc};
        nxt_acc  = acc_sum[ACC_W-1:0];
        nxt_tick = acc_sum[ACC_W];
    end

    // Registers the divider.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            acc_ff  <= '0;
            tick_ff <= 1'b0;
        end else begin
            acc_ff  <= nxt_acc;
            tick_ff <= nxt_tick;
        end
    end

    // ************************************************************
    // Trigger pin synchroniser.
    // ************************************************************

    // A level change is accepted once the second and third stages agree.
    always_comb begin
        nxt_trig_lvl = trig_lvl_ff;
        if (trig_s2_ff == trig_s3_ff) begin
            nxt_trig_lvl = trig_s3_ff;
        end
        trig_rise = (trig_s2_ff == trig_s3_ff) && trig_s3_ff && !trig_lvl_ff;
    end

    // Three stage synchroniser and the accepted level.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            trig_s1_ff  <= 1'b0;
            trig_s2_ff  <= 1'b0;
            trig_s3_ff  <= 1'b0;
            trig_lvl_ff <= 1'b0;
        end else begin
            trig_s1_ff  <= trigger_i;
            trig_s2_ff  <= trig_s1_ff;
            trig_s3_ff  <= trig_s2_ff;
            trig_lvl_ff <= nxt_trig_lvl;
        end
    end

    // ************************************************************
    // Exposure sequencer.
    // ************************************************************

    // Counts generator ticks through the exposure phase.
    always_comb begin
        start_req    = follower_ff ? master_start_i : trig_rise;
        nxt_state    = state_ff;
        nxt_count    = count_ff;
        nxt_exposure = exposure_ff;
        nxt_start    = 1'b0;
        nxt_done     = 1'b0;
        unique case (state_ff)
            ETG_IDLE: begin
                if (start_req && (exp_period_ff != EXP_RST)) begin
                    nxt_state    = ETG_EXPOSE;
                    nxt_count    = EXP_RST;
                    nxt_exposure = 1'b1;
                    nxt_start    = 1'b1;
                end
            end
            ETG_EXPOSE: begin
                if (tick_ff) begin
                    if ((count_ff + CNT_STEP) >= exp_period_ff) begin
                        nxt_state    = ETG_IDLE;
                        nxt_exposure = 1'b0;
                        nxt_done     = 1'b1;
                    end
                    nxt_count = count_ff + CNT_STEP;
                end
            end
        endcase
        if (clear_ff) begin
            nxt_state    = ETG_IDLE;
            nxt_count    = EXP_RST;
            nxt_exposure = 1'b0;
            nxt_start    = 1'b0;
            nxt_done     = 1'b0;
        end
    end

    // Registers the sequencer.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_ff    <= ETG_IDLE;
            count_ff    <= EXP_RST;
            exposure_ff <= 1'b0;
            start_ff    <= 1'b0;
            done_ff     <= 1'b0;
        end else begin
            state_ff    <= nxt_state;
            count_ff    <= nxt_count;
            exposure_ff <= nxt_exposure;
            start_ff    <= nxt_start;
            done_ff     <= nxt_done;
        end
    end

    // Outputs come straight from flip-flops.
    assign rdata_o     = rdata_ff;
    assign exposure_o  = exposure_ff;
    assign exp_start_o = start_ff;
    assign exp_done_o  = done_ff;
    assign tg_tick_o   = tick_ff;

endmodule

// >>> inc/etg_pkg.sv
package etg_pkg;

    // ************************************************************
    // Register bus layout.
    // ************************************************************
    localparam int unsigned ADDR_W     = 8;
    localparam int unsigned DATA_W     = 32;
    localparam logic [7:0]  CTRL_OFS   = 8'h00;  // Exposure timing control register.
    localparam logic [7:0]  STAT_OFS   = 8'h04;  // Generator status register.

    // ************************************************************
    // Field layout and reset values.
    // ************************************************************
    localparam int unsigned EXP_W      = 28;
    localparam int unsigned EXP_MSB    = 27;
    localparam int unsigned CLR_BIT    = 30;
    localparam int unsigned FOL_BIT    = 31;
    localparam int unsigned BUSY_BIT   = 31;
    localparam logic [27:0] EXP_RST    = 28'h0000000;
    localparam logic        FOL_RST    = 1'b0;
    localparam logic [31:0] DATA_ZERO  = 32'h00000000;
    localparam logic [27:0] CNT_STEP   = 28'h0000001;  // One generator tick of the counter.

    // ************************************************************
    // Generator clock rates and the tick accumulator.
    // ************************************************************
    localparam int unsigned ACC_W      = 24;
    localparam longint      CLK_HZ     = 64'd25000000;
    localparam longint      TG_MAIN_HZ = 64'd7372800;
    localparam longint      TG_ALT_HZ  = 64'd5000000;
    localparam longint      ACC_ONE    = 64'd1 << ACC_W;
    localparam logic [23:0] INC_MAIN   = ACC_W'((TG_MAIN_HZ * ACC_ONE) / CLK_HZ);
    localparam logic [23:0] INC_ALT    = ACC_W'((TG_ALT_HZ * ACC_ONE) / CLK_HZ);

    // Generator phases.
    typedef enum logic {
        ETG_IDLE,
        ETG_EXPOSE
    } etg_state_e;

endpackage

// >>> bench/etg_checker.sv
`timescale 1ns/1ps
module etg_checker
    import etg_pkg::*;
(
    input wire logic              clk_i,
    input wire logic              resetn_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    input wire logic              wr_i,
    input wire logic              rd_i,
    input wire logic [DATA_W-1:0] rdata_o,
    input wire logic              master_start_i,
    input wire logic              exposure_o,
    input wire logic              exp_start_o,
    input wire logic              exp_done_o,
    input wire logic              tg_tick_o
);
    // ********************************************************
    // Shadow of the stored fields and the port properties.
    // ********************************************************
    logic [27:0] per_ff;
    logic        fol_ff;
    logic [27:0] nxt_per;
    logic        nxt_fol;

    // Follows host writes so the checks know the stored period and mode.
    always_comb begin
        nxt_per = per_ff;
        nxt_fol = fol_ff;
        if (wr_i && addr_i == CTRL_OFS) begin
            nxt_per = wdata_i[EXP_MSB:0];
            nxt_fol = wdata_i[FOL_BIT];
        end
    end

    // Registers the shadow copy.
    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            per_ff <= EXP_RST;
            fol_ff <= FOL_RST;
        end else begin
            per_ff <= nxt_per;
            fol_ff <= nxt_fol;
        end
    end

    default clocking @(posedge clk_i); endclocking
    default disable iff (!resetn_i);

    // A clear write, and a follower start that no clear overrides.
    sequence s_clr_wr;
        wr_i && addr_i == CTRL_OFS && wdata_i[CLR_BIT];
    endsequence
    sequence s_fol_go;
        !exposure_o && fol_ff && per_ff != 0 && master_start_i
            && !$past(wr_i && addr_i == CTRL_OFS && wdata_i[CLR_BIT]);
    endsequence

    a_rd_idle: assert property (
        !$past(rd_i) |-> rdata_o == DATA_ZERO) else $error("read data not zero");
    a_ctrl_read: assert property (
        $past(rd_i && addr_i == CTRL_OFS) |-> rdata_o == {$past(fol_ff), 3'b000, $past(per_ff)})
        else $error("control read wrong");
    a_unmap_read: assert property (
        $past(rd_i && addr_i != CTRL_OFS && addr_i != STAT_OFS) |-> rdata_o == DATA_ZERO)
        else $error("unmapped read not zero");
    a_stat_busy: assert property (
        $past(rd_i && addr_i == STAT_OFS) |-> rdata_o[31:28] == {$past(exposure_o), 3'b000})
        else $error("status busy wrong");
    a_fol_start: assert property (
        s_fol_go |=> exp_start_o && exposure_o) else $error("follower start missed");
    a_start_edge: assert property (
        exp_start_o |-> exposure_o && !$past(exposure_o)) else $error("start pulse wrong");
    a_done_edge: assert property (
        exp_done_o |-> (!exposure_o && $past(exposure_o)) ##1 !exp_done_o)
        else $error("done pulse wrong");
    a_clr_stop: assert property (
        s_clr_wr |-> ##2 (!exposure_o && !exp_done_o)) else $error("clear did not stop");
    a_zero_idle: assert property (
        !exposure_o && per_ff == 0 |=> !exp_start_o) else $error("zero period started");
    a_tick_gap: assert property (
        tg_tick_o |=> !tg_tick_o) else $error("tick too fast");
endmodule

// >>> bench/tb_top.sv
`timescale 1ns/1ps
module tb_top
    import etg_pkg::*;
;
    // ********************************************************
    // Stimulus, read monitor and exposure scenarios.
    // ********************************************************
    logic              clk_i          = 1'b0;
    logic              resetn_i       = 1'b0;
    logic [ADDR_W-1:0] addr_i         = '0;
    logic [DATA_W-1:0] wdata_i        = '0;
    logic              wr_i           = 1'b0;
    logic              rd_i           = 1'b0;
    logic              trigger_i      = 1'b0;
    logic              master_start_i = 1'b0;
    logic              rd_d1          = 1'b0;
    logic [DATA_W-1:0] rdata_o;
    logic              exposure_o;
    logic              exp_start_o;
    logic              exp_done_o;
    logic              tg_tick_o;
    logic [31:0]       exp_q[$];
    logic [31:0]       seed           = 32'h75AB83A9;
    int                n_mismatch     = 0;
    int                checks         = 0;
    int                cyc            = 0;

    // Free-running 25 MHz clock.
    always #20 clk_i = ~clk_i;

    etg_ctrl dut_u (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .trigger_i(trigger_i),
        .master_start_i(master_start_i), .exposure_o(exposure_o), .exp_start_o(exp_start_o),
        .exp_done_o(exp_done_o), .tg_tick_o(tg_tick_o));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk(input logic [31:0] seen, input logic [31:0] want);
        checks++;
        if (seen !== want) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, want);
        end
    endtask

    task automatic stop_test();
        $display("mismatches %0d checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clk_i);
        wr_i    <= 1'b0;
    endtask

    // Notes the expected word, then issues a one-cycle read.
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clk_i);
        rd_i   <= 1'b0;
    endtask

    // Starts one exposure, optionally clears it, and counts its ticks.
    task automatic expo(input logic fol, input logic [27:0] p, input logic clr);
        int          t;
        int          n;
        logic [27:0] e;
        t = 0;
        n = 0;
        e = clr ? 28'h0 : p;
        wr(CTRL_OFS, {fol, 3'b000, p});
        @(posedge clk_i);
        trigger_i      <= !fol;
        master_start_i <= fol;
        @(posedge clk_i);
        master_start_i <= 1'b0;
        while (exposure_o !== 1'b1 && t < 40) begin @(posedge clk_i); t++; end
        chk(exp_start_o, 32'(p != 28'h0));
        if (clr) begin
            wr(CTRL_OFS, {fol, 3'b100, p});
            repeat (3) @(posedge clk_i);
            chk(exposure_o, 1'b0);
        end
        while (exposure_o === 1'b1 && t < 4000) begin n += tg_tick_o; @(posedge clk_i); t++; end
        chk(exp_done_o, 32'(!clr && p != 28'h0));
        chk(32'(n), 32'(e));
        rd(STAT_OFS, {4'h0, e});
        rd(CTRL_OFS, {fol, 3'b000, p});
        trigger_i <= 1'b0;
        repeat (5) @(posedge clk_i);
    endtask

    // Compares each read word one cycle after its strobe.
    always @(posedge clk_i) begin
        if (rd_d1) chk(rdata_o, exp_q.pop_front());
        rd_d1 <= rd_i;
    end

    // Cuts a hung run short.
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            stop_test();
        end
    end

    initial begin
        repeat (8) @(posedge clk_i);
        resetn_i <= 1'b1;
        rd(CTRL_OFS, DATA_ZERO);
        rd(STAT_OFS, DATA_ZERO);
        wr(8'h0C, 32'hFFFFFFFF);
        rd(8'h0C, DATA_ZERO);
        rd(CTRL_OFS, DATA_ZERO);
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            wr(CTRL_OFS, seed);
            rd(CTRL_OFS, seed & 32'h8FFFFFFF);
        end
        seed = lfsr(seed);
        // master channel stays on own timing
        expo(1'b0, {25'h0, seed[2:0]} + 28'h2, 1'b0);
        expo(1'b1, {25'h0, seed[5:3]} + 28'h1, 1'b0);
        expo(1'b1, 28'h40, 1'b1);
        expo(1'b1, 28'h0, 1'b0);
        stop_test();
    end
endmodule

bind etg_ctrl etg_checker chk_u (.clk_i(clk_i), .resetn_i(resetn_i), .addr_i(addr_i),
    .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .master_start_i(master_start_i), .exposure_o(exposure_o), .exp_start_o(exp_start_o),
    .exp_done_o(exp_done_o), .tg_tick_o(tg_tick_o));
